// *** logic/cirf_pkg.sv ***
/*
  Constants of the CAN interrupt flag block: offsets, flag bits, resets
  and bus answer codes.
  Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
*/
package cirf_pkg;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAG_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TX_PEND   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TX_ACK    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_ABORT_ACK = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_RX_PEND   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_RMT_PEND  = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_UNREAD    = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_MB_MASK   = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_NEW_MSG   = 8'h3C;

  // Flag bit positions
  localparam int unsigned BIT_MSG_ERR  = 13;
  localparam int unsigned BIT_SLEEP_BA = 12;
  localparam int unsigned BIT_OVERRUN  = 9;
  localparam int unsigned BIT_MB_EMPTY = 8;
  localparam int unsigned BIT_OVERLOAD = 7;
  localparam int unsigned BIT_BUS_OFF  = 6;

  localparam int unsigned FLAG_W = 16;
  // Flags that exist; everything else reads as zero
  localparam logic [15:0] FLAG_IMPL      = 16'h33C0;
  // Flags cleared by a write of one
  localparam logic [15:0] FLAG_W1C       = 16'h30C0;
  localparam logic [15:0] FLAG_RST       = 16'h0000;
  localparam logic [15:0] FLAG_MASK_RST  = 16'h0000;

  // Status register bit positions
  localparam int unsigned ST_BUS_OFF    = 0;
  localparam int unsigned ST_HALT_SLEEP = 1;
  localparam int unsigned ST_TEST_MODE  = 2;
  localparam int unsigned ST_SLEEP_MODE = 3;
  localparam int unsigned ST_RX_LEVEL   = 4;

  // Transmit error count at which bus-off is entered
  localparam int unsigned BUS_OFF_LIMIT = 256;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/cirf_sync.sv ***
/*
  Two-stage synchroniser for levels that arrive from outside the clock
  domain. Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module cirf_sync #(
  parameter int unsigned       WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// *** logic/cirf_top.sv ***
/*
  CAN interrupt request flags, with the mailbox pending and acknowledge
  bits that drive them, behind an AXI4-Lite slave.
  Assumes protocol and mailbox events arrive as one-cycle pulses on aclk;
  only the receive line comes from a pin and is synchronised here.
*/
// Notes on behaviour
// - 16-bit flag register at 0x008, reserved bits zero
// - Message error flag sets only in test mode
// - Message overload in test mode leaves flag unchanged
// - Writing one clears bits 13,12,7,6; zero ignored
// - Sleep activity flag sets on dominant rx in sleep
// - Overrun flag sets on receive into pending unmasked mailbox
// - Overrun clears when no unmasked unread bits remain
// - Mailbox empty is OR of unmasked acknowledge bits
// - Transmit or abort done clears that transmit pending
// - Overload flag sets on detected overload frame
// - Bus-off flag sets when error counter reaches 256
// - Bus-off flag also sets on recovery end, halt
// - Bus-off flag stays set; write one clears unless a set event lands in the same cycle
// - Sleep flag timing independent of halt/sleep status
`timescale 1ns/1ps
module cirf_top #(
  parameter int unsigned NUM_MB = 16,
  parameter int unsigned TEC_W  = 9,
  parameter int unsigned MB_W   = 4
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [cirf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [cirf_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        can_rx,
  input  wire logic                        test_mode,
  input  wire logic                        sleep_mode,
  input  wire logic                        msg_error_evt,
  input  wire logic                        msg_overload_evt,
  input  wire logic                        overload_frame_evt,
  input  wire logic [TEC_W-1:0]            transmit_error_counter,
  input  wire logic                        bus_off_recovered_evt,
  input  wire logic                        bus_off_to_halt_evt,
  input  wire logic                        global_bus_off_status,
  input  wire logic                        halt_sleep_status,
  input  wire logic                        rx_msg_evt,
  input  wire logic [MB_W-1:0]             rx_msg_mailbox,
  input  wire logic                        rx_msg_remote,
  input  wire logic                        tx_done_evt,
  input  wire logic                        abort_done_evt,
  input  wire logic [MB_W-1:0]             tx_mailbox,
  output logic                             rx_msg_store,
  output logic [NUM_MB-1:0]                transmit_pending_bits,
  output logic                             irq
);
  localparam logic [TEC_W-1:0] TEC_LIMIT = TEC_W'(cirf_pkg::BUS_OFF_LIMIT);

  logic [cirf_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [cirf_pkg::ADDR_W-1:0] aw_word;
  logic [31:0]                 w_data_reg;
  logic [3:0]                  w_strb_reg;
  logic [31:0]                 w_ones;
  logic [31:0]                 w_lanes;
  logic                        wr_do;
  logic                        wr_hit;
  logic [31:0]                 rd_word;
  logic                        rd_hit;
  logic [cirf_pkg::ADDR_W-1:0] ar_word;

  logic [15:0]        flag_reg;
  logic [15:0]        flag_next;
  logic [15:0]        flag_mask_reg;
  logic [NUM_MB-1:0]  transmit_acknowledge_bits;
  logic [NUM_MB-1:0]  abort_acknowledge_bits;
  logic [NUM_MB-1:0]  receive_pending_bits;
  logic [NUM_MB-1:0]  remote_pending_bits;
  logic [NUM_MB-1:0]  unread_message_status_bits;
  logic [NUM_MB-1:0]  mailbox_mask_bits;
  logic [NUM_MB-1:0]  new_message_control;
  logic [NUM_MB-1:0]  rx_sel;
  logic [NUM_MB-1:0]  tx_sel;
  logic               rx_level;
  logic               bus_off_cond_reg;
  logic               rx_busy;
  logic               overrun_set;

  cirf_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b1)
  ) u_rx_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (can_rx),
    .sync_out (rx_level)
  );

  // Write address and data are taken independently and held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr_reg   <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_reg   <= s_axi_awaddr;
    end else if (wr_do) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end else if (wr_do) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign wr_do   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign aw_word = {aw_addr_reg[cirf_pkg::ADDR_W-1:2], 2'b00};

  // Only bytes whose strobe is high carry ones into the register logic
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      w_ones[b*8 +: 8] = w_strb_reg[b] ? w_data_reg[b*8 +: 8] : 8'h00;
      w_lanes[b*8 +: 8] = {8{w_strb_reg[b]}};
    end
  end

  always_comb begin
    unique case (aw_word)
      cirf_pkg::OFS_FLAGS, cirf_pkg::OFS_FLAG_MASK, cirf_pkg::OFS_STATUS,
      cirf_pkg::OFS_TX_PEND, cirf_pkg::OFS_TX_ACK, cirf_pkg::OFS_ABORT_ACK,
      cirf_pkg::OFS_RX_PEND, cirf_pkg::OFS_RMT_PEND, cirf_pkg::OFS_UNREAD,
      cirf_pkg::OFS_MB_MASK, cirf_pkg::OFS_NEW_MSG: wr_hit = 1'b1;
      default:                                       wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cirf_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? cirf_pkg::RESP_OKAY : cirf_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path: data registered on the same edge that takes the address
  assign ar_word = {s_axi_araddr[cirf_pkg::ADDR_W-1:2], 2'b00};

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    unique case (ar_word)
      cirf_pkg::OFS_FLAGS:     rd_word[15:0] = flag_reg & cirf_pkg::FLAG_IMPL;
      cirf_pkg::OFS_FLAG_MASK: rd_word[15:0] = flag_mask_reg;
      cirf_pkg::OFS_STATUS: begin
        rd_word[cirf_pkg::ST_BUS_OFF]    = global_bus_off_status;
        rd_word[cirf_pkg::ST_HALT_SLEEP] = halt_sleep_status;
        rd_word[cirf_pkg::ST_TEST_MODE]  = test_mode;
        rd_word[cirf_pkg::ST_SLEEP_MODE] = sleep_mode;
        rd_word[cirf_pkg::ST_RX_LEVEL]   = rx_level;
      end
      cirf_pkg::OFS_TX_PEND:   rd_word[NUM_MB-1:0] = transmit_pending_bits;
      cirf_pkg::OFS_TX_ACK:    rd_word[NUM_MB-1:0] = transmit_acknowledge_bits;
      cirf_pkg::OFS_ABORT_ACK: rd_word[NUM_MB-1:0] = abort_acknowledge_bits;
      cirf_pkg::OFS_RX_PEND:   rd_word[NUM_MB-1:0] = receive_pending_bits;
      cirf_pkg::OFS_RMT_PEND:  rd_word[NUM_MB-1:0] = remote_pending_bits;
      cirf_pkg::OFS_UNREAD:    rd_word[NUM_MB-1:0] = unread_message_status_bits;
      cirf_pkg::OFS_MB_MASK:   rd_word[NUM_MB-1:0] = mailbox_mask_bits;
      cirf_pkg::OFS_NEW_MSG:   rd_word[NUM_MB-1:0] = new_message_control;
      default:                 rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= cirf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? cirf_pkg::RESP_OKAY : cirf_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // One-hot mailbox selects; indices beyond NUM_MB select nothing
  always_comb begin
    rx_sel = '0;
    tx_sel = '0;
    for (int i = 0; i < NUM_MB; i++) begin
      rx_sel[i] = rx_msg_evt && (rx_msg_mailbox == MB_W'(i));
      tx_sel[i] = (tx_done_evt || abort_done_evt) && (tx_mailbox == MB_W'(i));
    end
  end

  assign rx_busy     = |((receive_pending_bits | remote_pending_bits) & rx_sel);
  assign overrun_set = rx_busy && |(rx_sel & ~mailbox_mask_bits);

  // Software sets a transmit request; completion or abort retires it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_pending_bits <= '0;
    end else begin
      transmit_pending_bits <= (transmit_pending_bits
        | ((wr_do && aw_word == cirf_pkg::OFS_TX_PEND) ? w_ones[NUM_MB-1:0] : '0))
        & ~tx_sel;
    end
  end

  // Acknowledge bits: hardware set wins over a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_acknowledge_bits <= '0;
      abort_acknowledge_bits    <= '0;
    end else begin
      transmit_acknowledge_bits <= (tx_done_evt ? tx_sel : '0)
        | (transmit_acknowledge_bits
           & ~((wr_do && aw_word == cirf_pkg::OFS_TX_ACK) ? w_ones[NUM_MB-1:0] : '0));
      abort_acknowledge_bits <= (abort_done_evt && !tx_done_evt ? tx_sel : '0)
        | (abort_acknowledge_bits
           & ~((wr_do && aw_word == cirf_pkg::OFS_ABORT_ACK) ? w_ones[NUM_MB-1:0] : '0));
    end
  end

  // Receive side pending and unread bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_pending_bits       <= '0;
      remote_pending_bits        <= '0;
      unread_message_status_bits <= '0;
    end else begin
      receive_pending_bits <= (rx_msg_remote ? '0 : rx_sel)
        | (receive_pending_bits
           & ~((wr_do && aw_word == cirf_pkg::OFS_RX_PEND) ? w_ones[NUM_MB-1:0] : '0));
      remote_pending_bits <= (rx_msg_remote ? rx_sel : '0)
        | (remote_pending_bits
           & ~((wr_do && aw_word == cirf_pkg::OFS_RMT_PEND) ? w_ones[NUM_MB-1:0] : '0));
      unread_message_status_bits <= (rx_busy ? rx_sel : '0)
        | (unread_message_status_bits
           & ~((wr_do && aw_word == cirf_pkg::OFS_UNREAD) ? w_ones[NUM_MB-1:0] : '0));
    end
  end

  // Mailbox storage is told whether to keep the new message
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_msg_store <= 1'b0;
    end else begin
      rx_msg_store <= rx_msg_evt && (!rx_busy || |(rx_sel & new_message_control));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mailbox_mask_bits   <= '0;
      new_message_control <= '0;
      flag_mask_reg       <= cirf_pkg::FLAG_MASK_RST;
    end else if (wr_do) begin
      if (aw_word == cirf_pkg::OFS_MB_MASK) begin
        mailbox_mask_bits <= w_ones[NUM_MB-1:0] | (mailbox_mask_bits & ~w_lanes[NUM_MB-1:0]);
      end
      if (aw_word == cirf_pkg::OFS_NEW_MSG) begin
        new_message_control <= w_ones[NUM_MB-1:0] | (new_message_control & ~w_lanes[NUM_MB-1:0]);
      end
      if (aw_word == cirf_pkg::OFS_FLAG_MASK) begin
        flag_mask_reg <= w_ones[15:0] | (flag_mask_reg & ~w_lanes[15:0]);
      end
    end
  end

  // Bus-off entry is the edge of the counter crossing the limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_off_cond_reg <= 1'b0;
    end else begin
      bus_off_cond_reg <= transmit_error_counter >= TEC_LIMIT;
    end
  end

  // Flag updates; a set in the same cycle as a clearing write wins
  always_comb begin
    logic [15:0] clr;
    clr = '0;
    if (wr_do && aw_word == cirf_pkg::OFS_FLAGS) begin
      clr = w_ones[15:0] & cirf_pkg::FLAG_W1C;
    end
    flag_next = flag_reg & ~clr;
    if (msg_error_evt && test_mode && !msg_overload_evt) begin
      flag_next[cirf_pkg::BIT_MSG_ERR] = 1'b1;
    end
    // Driven only by sleep_mode and the synchronised line, never by the halt/sleep status
    if (sleep_mode && !rx_level) begin
      flag_next[cirf_pkg::BIT_SLEEP_BA] = 1'b1;
    end
    flag_next[cirf_pkg::BIT_OVERRUN] = overrun_set
      || (flag_reg[cirf_pkg::BIT_OVERRUN]
          && |(unread_message_status_bits & ~mailbox_mask_bits));
    flag_next[cirf_pkg::BIT_MB_EMPTY] =
      |((transmit_acknowledge_bits | abort_acknowledge_bits) & ~mailbox_mask_bits);
    if (overload_frame_evt) begin
      flag_next[cirf_pkg::BIT_OVERLOAD] = 1'b1;
    end
    if ((transmit_error_counter >= TEC_LIMIT && !bus_off_cond_reg)
        || bus_off_recovered_evt || bus_off_to_halt_evt) begin
      flag_next[cirf_pkg::BIT_BUS_OFF] = 1'b1;
    end
    flag_next = flag_next & cirf_pkg::FLAG_IMPL;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= cirf_pkg::FLAG_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // A set mask bit blocks its flag from the interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_reg & ~flag_mask_reg & cirf_pkg::FLAG_IMPL);
    end
  end
endmodule

// *** verification/cirf_assertions.sv ***
/*
  Checker for the CAN interrupt flag block; sees the top ports only.
  Assumes full-word writes and no mask write next to an event: the mask
  copy lags the design by one edge.
*/
`timescale 1ns/1ps
module cirf_checker #(
  parameter int unsigned NUM_MB = 16,
  parameter int unsigned TEC_W  = 9,
  parameter int unsigned MB_W   = 4
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic [cirf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic [31:0]                 s_axi_wdata,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic [cirf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic                        s_axi_rvalid,
  input wire logic                        test_mode,
  input wire logic                        msg_error_evt,
  input wire logic                        msg_overload_evt,
  input wire logic                        overload_frame_evt,
  input wire logic [TEC_W-1:0]            transmit_error_counter,
  input wire logic                        bus_off_recovered_evt,
  input wire logic                        bus_off_to_halt_evt,
  input wire logic                        tx_done_evt,
  input wire logic                        abort_done_evt,
  input wire logic [MB_W-1:0]             tx_mailbox,
  input wire logic [NUM_MB-1:0]           transmit_pending_bits,
  input wire logic                        rx_msg_store,
  input wire logic                        irq
);
  logic [7:0]  wa_q;
  logic [7:0]  ra_q;
  logic [15:0] wd_q;
  logic [15:0] msk_q;
  logic        bv_q;
  wire         wact = s_axi_bvalid && !bv_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q  <= 1'b0;
      msk_q <= 16'h0000;
    end else begin
      bv_q <= s_axi_bvalid;
      if (wact && wa_q == cirf_pkg::OFS_FLAG_MASK) begin
        msk_q <= wd_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      wa_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_q <= s_axi_wdata[15:0];
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ovl;
    overload_frame_evt && !msk_q[7] |-> ##2 irq;
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("no irq after overload");
  property p_err;
    msg_error_evt && test_mode && !msg_overload_evt && !msk_q[13] |-> ##2 irq;
  endproperty
  a_err: assert property (p_err)
    else $error("no irq after message error");
  property p_boff;
    int'(transmit_error_counter) >= 256 && int'($past(transmit_error_counter)) < 256
      && !msk_q[6] |-> ##2 irq;
  endproperty
  a_boff: assert property (p_boff)
    else $error("no irq on bus-off entry");
  property p_recov;
    (bus_off_recovered_evt || bus_off_to_halt_evt) && !msk_q[6] |-> ##2 irq;
  endproperty
  a_recov: assert property (p_recov)
    else $error("no irq on bus-off exit");
  // Every way down for irq goes through a register write
  property p_fall;
    $fell(irq) |-> $past(wact) || $past(wact, 2);
  endproperty
  a_fall: assert property (p_fall)
    else $error("irq dropped without a write");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read answer late");
  property p_rsv;
    s_axi_rvalid && ra_q == cirf_pkg::OFS_FLAGS |-> (s_axi_rdata & ~32'h0000_33C0) == '0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits nonzero");
  property p_txp;
    tx_done_evt || abort_done_evt |=> !transmit_pending_bits[$past(tx_mailbox)];
  endproperty
  a_txp: assert property (p_txp)
    else $error("transmit pending not cleared");

  c_irq: cover property ($rose(irq));
  c_store: cover property (rx_msg_store);
  c_tx: cover property (tx_done_evt ##[1:100] abort_done_evt);
endmodule

bind cirf_top cirf_checker #(.NUM_MB(NUM_MB), .TEC_W(TEC_W), .MB_W(MB_W)) u_chk (.*);

// *** verification/cirf_can_node.sv ***
/*
  Behavioural CAN side: bus level and protocol or mailbox event pulses.
  Assumes one clock; each pulse lasts exactly one cycle.
*/
`timescale 1ns/1ps
module cirf_can_node (
  input  wire logic aclk,
  output logic       can_rx,
  output logic       overload_frame_evt,
  output logic       msg_error_evt,
  output logic       msg_overload_evt,
  output logic       bus_off_recovered_evt,
  output logic       bus_off_to_halt_evt,
  output logic       rx_msg_evt,
  output logic [3:0] rx_msg_mailbox,
  output logic       rx_msg_remote,
  output logic       tx_done_evt,
  output logic       abort_done_evt,
  output logic [3:0] tx_mailbox
);
  logic [7:0] ev = 8'h00;

  assign {overload_frame_evt, msg_error_evt, msg_overload_evt, bus_off_recovered_evt,
          bus_off_to_halt_evt, rx_msg_evt, tx_done_evt, abort_done_evt} = ev;

  initial begin
    can_rx = 1'b1;
    rx_msg_mailbox = 4'h0;
    tx_mailbox = 4'h0;
    rx_msg_remote = 1'b0;
  end

  // Qualifiers turn to their inverse after the pulse so stale use shows up
  task automatic pulse(input logic [7:0] e, input logic [3:0] mb, input logic rmt);
    @(posedge aclk);
    ev <= e;
    rx_msg_mailbox <= mb;
    tx_mailbox <= mb;
    rx_msg_remote <= rmt;
    @(posedge aclk);
    ev <= 8'h00;
    rx_msg_mailbox <= ~mb;
    tx_mailbox <= ~mb;
    rx_msg_remote <= ~rmt;
  endtask

  // Recessive is the pulled-up idle level between dominant bits
  task automatic dominant(input int n);
    @(posedge aclk);
    can_rx <= 1'b0;
    repeat (n) @(posedge aclk);
    can_rx <= 1'b1;
  endtask
endmodule

// *** verification/tb.sv ***
/*
  Top bench: AXI4-Lite master tasks and directed flag tests.
  Assumes the checker binds itself and the CAN side model drives events.
*/
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb;
  localparam logic [7:0] FLG = cirf_pkg::OFS_FLAGS;
  localparam logic [7:0] MSK = cirf_pkg::OFS_FLAG_MASK;
  localparam logic [7:0] STS = cirf_pkg::OFS_STATUS;
  localparam logic [7:0] TXP = cirf_pkg::OFS_TX_PEND;
  localparam logic [7:0] UNR = cirf_pkg::OFS_UNREAD;
  localparam logic [7:0] MBM = cirf_pkg::OFS_MB_MASK;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        test_mode = 1'b0, sleep_mode = 1'b0, halt_sleep_status = 1'b0;
  logic        global_bus_off_status = 1'b0;
  logic [8:0]  transmit_error_counter = 9'h000;
  logic        can_rx, msg_error_evt, msg_overload_evt, overload_frame_evt;
  logic        bus_off_recovered_evt, bus_off_to_halt_evt, rx_msg_evt, rx_msg_remote;
  logic        tx_done_evt, abort_done_evt, rx_msg_store, irq;
  logic [3:0]  rx_msg_mailbox, tx_mailbox;
  logic [15:0] transmit_pending_bits;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;

  cirf_top uut (.*);
  cirf_can_node node (.*);

  always #2.5 aclk = ~aclk;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdat, e)
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(FLG, 32'h0000_0000);
    rchk(MSK, 32'h0000_0000);
    wr(FLG, 32'hFFFF_FFFF);
    rchk(FLG, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    `CHK(resp, cirf_pkg::RESP_SLVERR)
    rd(8'h04);
    `CHK(resp, cirf_pkg::RESP_SLVERR)
    node.pulse(8'h80, 4'h0, 1'b0);
    rchk(FLG, 32'h0000_0080);
    `CHK(irq, 1'b1)
    wr(FLG, 32'h0000_0000);
    rchk(FLG, 32'h0000_0080);
    wr(MSK, 32'h0000_0080);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    wr(FLG, 32'h0000_0080);
    rchk(FLG, 32'h0000_0000);
    wr(MSK, 32'h0000_0000);
    node.pulse(8'h40, 4'h0, 1'b0);
    rchk(FLG, 32'h0000_0000);
    test_mode <= 1'b1;
    node.pulse(8'h60, 4'h0, 1'b0);
    rchk(FLG, 32'h0000_0000);
    node.pulse(8'h40, 4'h0, 1'b0);
    rchk(FLG, 32'h0000_2000);
    wr(FLG, 32'h0000_2000);
    rchk(FLG, 32'h0000_0000);
    test_mode <= 1'b0;
    sleep_mode <= 1'b1;
    node.dominant(3);
    rchk(FLG, 32'h0000_1000);
    sleep_mode <= 1'b0;
    wr(FLG, 32'h0000_1000);
    node.dominant(3);
    rchk(FLG, 32'h0000_0000);
    transmit_error_counter <= 9'h0FF;
    rchk(FLG, 32'h0000_0000);
    transmit_error_counter <= 9'h100;
    {global_bus_off_status, halt_sleep_status} <= 2'b11;
    rchk(FLG, 32'h0000_0040);
    wr(FLG, 32'h0000_0040);
    rchk(FLG, 32'h0000_0000);
    rchk(STS, 32'h0000_0013);
    transmit_error_counter <= 9'h000;
    {global_bus_off_status, halt_sleep_status} <= 2'b00;
    node.pulse(8'h10, 4'h0, 1'b0);
    rchk(STS, 32'h0000_0010);
    rchk(FLG, 32'h0000_0040);
    wr(FLG, 32'h0000_0040);
    node.pulse(8'h08, 4'h0, 1'b0);
    rchk(FLG, 32'h0000_0040);
    wr(FLG, 32'h0000_0040);
    wr(TXP, 32'h0000_0003);
    rchk(TXP, 32'h0000_0003);
    node.pulse(8'h02, 4'h0, 1'b0);
    rchk(FLG, 32'h0000_0100);
    `CHK(transmit_pending_bits, 16'h0002)
    node.pulse(8'h01, 4'h1, 1'b0);
    @(negedge aclk);
    `CHK(transmit_pending_bits, 16'h0000)
    wr(FLG, 32'h0000_0100);
    rchk(FLG, 32'h0000_0100);
    wr(MBM, 32'h0000_0003);
    rchk(FLG, 32'h0000_0000);
    wr(MBM, 32'h0000_0000);
    wr(cirf_pkg::OFS_TX_ACK, 32'h0000_0001);
    rchk(FLG, 32'h0000_0100);
    wr(cirf_pkg::OFS_ABORT_ACK, 32'h0000_0002);
    rchk(FLG, 32'h0000_0000);
    node.pulse(8'h04, 4'h2, 1'b0);
    @(negedge aclk);
    `CHK(rx_msg_store, 1'b1)
    node.pulse(8'h04, 4'h2, 1'b0);
    @(negedge aclk);
    `CHK(rx_msg_store, 1'b0)
    rchk(FLG, 32'h0000_0200);
    rchk(UNR, 32'h0000_0004);
    wr(cirf_pkg::OFS_NEW_MSG, 32'h0000_0004);
    node.pulse(8'h04, 4'h2, 1'b1);
    @(negedge aclk);
    `CHK(rx_msg_store, 1'b1)
    wr(FLG, 32'h0000_0200);
    rchk(FLG, 32'h0000_0200);
    wr(UNR, 32'h0000_0004);
    rchk(FLG, 32'h0000_0000);
    node.pulse(8'h04, 4'h2, 1'b0);
    rchk(FLG, 32'h0000_0200);
    wr(MBM, 32'h0000_0004);
    rchk(FLG, 32'h0000_0000);
    give_verdict;
  end
endmodule
